// ### core/tt_defines.svh
// register indices, field positions and reset values of the timer unit
//
// Behaviour
// - timers 0 and 1 are 8-bit down counters stepping once per selected tick
// - reading a count register gives the live count; writing sets reload
// - capture copies the count; a second register shows its ones-complement
// - run 1 preloads and starts, 0 stops; rewriting 1 ignored on timers 0/1
// - reload-disable 0 reloads after underflow, 1 does not
// - timer 0 capture source: 1 selects port0 pin0, 0 selects ir input
// - timer 1 capture source: 1 selects port0 pin1, 0 selects ir input
// - capture edge select: 0 rising edge, 1 falling edge
// - external clock edge select: 0 rising edge, 1 falling edge
// - timer 0 clock: 00 osc, 01 osc/2, 10 osc/4, 11 port0 pin7
// - timer 1 clock as timer 0 but 11 selects port0 pin6
// - timer 2 is 16-bit, count and reload through low and high bytes
// - timer 2 clock code 11 selects port0 pin5; timer 2 has no capture
// - timer 1 mirrors timer 0 with its own registers
// - underflow sets a sticky event flag until software clears it
// - interrupt request only when enable bit 3, 2 or 1 is set
// - ir capture source valid only while ir direction select is 1
`ifndef TT_DEFINES_SVH
`define TT_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define TT_IDX_IRQ_EN      10'h0e2
`define TT_IDX_EVT         10'h0e3
`define TT_IDX_T2_LO       10'h0e5
`define TT_IDX_T2_HI       10'h0e6
`define TT_IDX_T2_CTL      10'h0e7
`define TT_IDX_T0_CNT      10'h0e8
`define TT_IDX_T0_CTL      10'h0e9
`define TT_IDX_T0_CAP      10'h0ea
`define TT_IDX_T0_CAPB     10'h0eb
`define TT_IDX_T1_CNT      10'h0ec
`define TT_IDX_T1_CTL      10'h0ed
`define TT_IDX_T1_CAP      10'h0ee
`define TT_IDX_T1_CAPB     10'h0ef
`define TT_IDX_IR_CTL      10'h0fa

// ****************************************************************
// control field positions
// ****************************************************************
`define TT_CTL_RUN         7
`define TT_CTL_RLD_DIS     6
`define TT_CTL_CLK_EDGE    5
`define TT_CTL_CAP_SRC     4
`define TT_CTL_CAP_EDGE    3
`define TT_CTL_SRC_HI      1
`define TT_CTL_SRC_LO      0
`define TT_CTL_WMASK       8'hfb
`define TT_IR_DIR_BIT      0
`define TT_IR_READ_BIT     7

// ****************************************************************
// pins, event bits, reset values
// ****************************************************************
`define TT_PIN_T0_CLK      7
`define TT_PIN_T1_CLK      6
`define TT_PIN_T2_CLK      5
`define TT_PIN_T0_CAP      0
`define TT_PIN_T1_CAP      1
`define TT_EVT_BIT_T0      3
`define TT_CTL_RESET       8'h00
`define TT_CNT_RESET       16'h0000
`define TT_BYTE_RESET      8'h00
`define TT_WORD_ZERO       32'h0000_0000
`define TT_SYNC_RESET      9'h1ff

`endif

// ### core/tt_pkg.sv
// types shared by the timer unit
package tt_pkg;
  // clock source codes of the control register
  typedef enum logic [1:0] {
    TT_SRC_OSC  = 2'b00,
    TT_SRC_DIV2 = 2'b01,
    TT_SRC_DIV4 = 2'b10,
    TT_SRC_PIN  = 2'b11
  } tt_clk_src_t;

  typedef logic [15:0] tt_count_t;
  typedef logic [7:0]  tt_byte_t;
endpackage

// ### core/tt_timer_unit.sv
// three down-counting timers, timers 0 and 1 with capture, reached over apb
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "tt_defines.svh"

module tt_timer_unit #(
  parameter int NUM_TIMERS = 3,
  parameter int ADDR_W     = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        port0_pin,
  input  wire logic              ir_pin_input,
  output logic [2:0]             timer_irq
);
  import tt_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (NUM_TIMERS != 3) begin : g_bad_count
    $error("timer unit is built for exactly three timers");
  end
  if (ADDR_W < 12) begin : g_bad_addr
    $error("address must reach the top register index");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic [8:0] sync_c;
  logic [8:0] next_sync_a;
  logic [8:0] next_sync_b;
  logic [8:0] next_sync_c;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;

  // two flops then an edge flop
  always_comb begin
    next_sync_a = {ir_pin_input, port0_pin};
    next_sync_b = sync_a;
    next_sync_c = sync_b;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= `TT_SYNC_RESET; // pulled-up idle, no false edge
      sync_b <= `TT_SYNC_RESET;
      sync_c <= `TT_SYNC_RESET;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
    end
  end

  // edges are taken only from the settled stages
  assign pin_rise = sync_b & ~sync_c;
  assign pin_fall = ~sync_b & sync_c;

  // ****************************************************************
  // shared prescaler and apb decode
  // ****************************************************************
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic [9:0] idx;
  logic       wr_en;
  logic       ir_dir;
  logic       next_ir_dir;
  logic       ir_valid;

  // one free divider serves every timer; phases are shared by design
  always_comb begin
    next_div_cnt = div_cnt + 2'b01;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 2'b00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  assign idx   = paddr[11:2];
  // writes land only at the edge where pready is sampled high
  assign wr_en = psel & penable & pready & pwrite & pstrb[0];

  // ir direction select, pin in input mode when set
  always_comb begin
    next_ir_dir = ir_dir;
    if (wr_en && idx == `TT_IDX_IR_CTL) begin
      next_ir_dir = pwdata[`TT_IR_DIR_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_dir <= 1'b0;
    end else begin
      ir_dir <= next_ir_dir;
    end
  end

  // ir capture only in input mode
  assign ir_valid = ir_dir;

  // ****************************************************************
  // per-timer counters
  // ****************************************************************
  localparam logic [9:0] CTL_IDX [3] = '{`TT_IDX_T0_CTL,
                                         `TT_IDX_T1_CTL,
                                         `TT_IDX_T2_CTL};
  localparam logic [9:0] LO_IDX  [3] = '{`TT_IDX_T0_CNT,
                                         `TT_IDX_T1_CNT,
                                         `TT_IDX_T2_LO};
  localparam int         CLK_PIN [3] = '{`TT_PIN_T0_CLK,
                                         `TT_PIN_T1_CLK,
                                         `TT_PIN_T2_CLK};
  localparam int         CAP_PIN [2] = '{`TT_PIN_T0_CAP,
                                         `TT_PIN_T1_CAP};

  logic [2:0] underflow;

  for (genvar t = 0; t < 3; t++) begin : g_tmr
    tt_count_t count;
    tt_count_t reload;
    tt_byte_t  ctl;
    tt_count_t next_count;
    tt_count_t next_reload;
    tt_byte_t  next_ctl;
    logic      tick;
    logic      ext_edge;
    logic      uf;
    tt_byte_t  cap;

    assign ext_edge = ctl[`TT_CTL_CLK_EDGE] ? pin_fall[CLK_PIN[t]]
                                            : pin_rise[CLK_PIN[t]];

    always_comb begin
      next_count  = count;
      next_reload = reload;
      next_ctl    = ctl;
      uf          = 1'b0;
      case (tt_clk_src_t'(ctl[`TT_CTL_SRC_HI:`TT_CTL_SRC_LO]))
        TT_SRC_OSC: begin
          tick = 1'b1;
        end
        TT_SRC_DIV2: begin
          tick = div_cnt[0];
        end
        TT_SRC_DIV4: begin
          tick = &div_cnt;
        end
        default: begin
          tick = ext_edge;
        end
      endcase
      if (ctl[`TT_CTL_RUN] && tick) begin
        if (count == `TT_CNT_RESET) begin
          // underflow on the tick after zero
          uf = 1'b1;
          if (!ctl[`TT_CTL_RLD_DIS]) begin
            next_count = reload;
          end else begin
            next_ctl[`TT_CTL_RUN] = 1'b0;
          end
        end else begin
          next_count = count - 16'h0001;
        end
      end
      // count writes set the reload value only
      if (wr_en && idx == LO_IDX[t]) begin
        next_reload[7:0] = pwdata[7:0];
      end
      if (t == 2 && wr_en && idx == `TT_IDX_T2_HI) begin
        next_reload[15:8] = pwdata[7:0];
      end
      if (wr_en && idx == CTL_IDX[t]) begin
        next_ctl = pwdata[7:0] & `TT_CTL_WMASK;
        // start preloads; restart ignored on 8-bit timers
        if (pwdata[`TT_CTL_RUN] && (!ctl[`TT_CTL_RUN] || t == 2)) begin
          next_count = reload;
        end
      end
    end

    // stopped, reload on, undivided clock after reset
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        count  <= `TT_CNT_RESET;
        reload <= `TT_CNT_RESET;
        ctl    <= `TT_CTL_RESET;
      end else begin
        count  <= next_count;
        reload <= next_reload;
        ctl    <= next_ctl;
      end
    end

    assign underflow[t] = uf;

    if (t < 2) begin : g_cap
      tt_byte_t next_cap;
      logic     src;
      logic     trig;

      assign src = ctl[`TT_CTL_CAP_SRC];
      always_comb begin
        if (src) begin
          trig = ctl[`TT_CTL_CAP_EDGE] ? pin_fall[CAP_PIN[t]]
                                       : pin_rise[CAP_PIN[t]];
        end else begin
          trig = ir_valid & (ctl[`TT_CTL_CAP_EDGE] ? pin_fall[8]
                                                   : pin_rise[8]);
        end
        next_cap = cap;
        // copy live count on a trigger
        if (trig) begin
          next_cap = count[7:0];
        end
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cap <= `TT_BYTE_RESET;
        end else begin
          cap <= next_cap;
        end
      end
    end else begin : g_nocap
      assign cap = `TT_BYTE_RESET;
    end
  end

  // ****************************************************************
  // event flags and interrupt requests
  // ****************************************************************
  logic [2:0] evt;
  logic [2:0] irq_en;
  logic [2:0] next_evt;
  logic [2:0] next_irq_en;
  logic [2:0] next_timer_irq;

  always_comb begin
    next_evt    = evt;
    next_irq_en = irq_en;
    if (wr_en && idx == `TT_IDX_IRQ_EN) begin
      next_irq_en = pwdata[`TT_EVT_BIT_T0 -: 3];
    end
    // writing 0 to a flag clears it
    if (wr_en && idx == `TT_IDX_EVT) begin
      next_evt = evt & pwdata[`TT_EVT_BIT_T0 -: 3];
    end
    // sticky flag, set wins over clear
    next_evt = next_evt | {underflow[0], underflow[1], underflow[2]};
    // gate each flag by its enable
    next_timer_irq = next_evt & next_irq_en;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt       <= 3'b000;
      irq_en    <= 3'b000;
      timer_irq <= 3'b000;
    end else begin
      evt       <= next_evt;
      irq_en    <= next_irq_en;
      timer_irq <= next_timer_irq;
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [7:0]  rd;
  logic        hit;

  // read mux; write-only registers read as zero
  always_comb begin
    rd  = `TT_BYTE_RESET;
    hit = 1'b1;
    case (idx)
      `TT_IDX_IRQ_EN, `TT_IDX_T0_CTL, `TT_IDX_T1_CTL,
      `TT_IDX_T2_CTL: begin
        rd = `TT_BYTE_RESET;
      end
      `TT_IDX_EVT: begin
        rd[`TT_EVT_BIT_T0 -: 3] = evt;
      end
      `TT_IDX_T2_LO: begin
        rd = g_tmr[2].count[7:0];
      end
      `TT_IDX_T2_HI: begin
        rd = g_tmr[2].count[15:8];
      end
      `TT_IDX_T0_CNT: begin
        rd = g_tmr[0].count[7:0];
      end
      `TT_IDX_T0_CAP: begin
        rd = g_tmr[0].cap;
      end
      `TT_IDX_T0_CAPB: begin
        rd = ~g_tmr[0].cap;
      end
      `TT_IDX_T1_CNT: begin
        rd = g_tmr[1].count[7:0];
      end
      `TT_IDX_T1_CAP: begin
        rd = g_tmr[1].cap;
      end
      `TT_IDX_T1_CAPB: begin
        rd = ~g_tmr[1].cap;
      end
      `TT_IDX_IR_CTL: begin
        rd[`TT_IR_READ_BIT] = sync_b[8];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // one wait state keeps every apb output on a flop
    next_pready  = psel & penable & ~pready;
    next_prdata  = `TT_WORD_ZERO;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_prdata  = {24'h00_0000, rd};
      next_pslverr = ~hit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= `TT_WORD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// ### bench/tt_timer_unit_properties.sv
// checker for bus handshake and interrupt gating of the timer unit
`timescale 1ns/1ps
`include "tt_defines.svh"
module tt_timer_unit_properties #(
  parameter int NUM_TIMERS = 3,
  parameter int ADDR_W     = 12
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [7:0]        port0_pin,
  input wire logic              ir_pin_input,
  input wire logic [2:0]        timer_irq
);
  logic [9:0] idx;
  logic       mapped;
  logic       flag_wr;
  logic [2:0] irq_en;
  logic [2:0] next_irq_en;

  // decoded index of the current access
  assign idx     = paddr[11:2];
  assign mapped  = idx inside {`TT_IDX_IRQ_EN, `TT_IDX_EVT, `TT_IDX_IR_CTL,
                               [`TT_IDX_T2_LO:`TT_IDX_T1_CAPB]};
  assign flag_wr = pready && pwrite && idx inside {`TT_IDX_IRQ_EN, `TT_IDX_EVT};

  // mirror of the timer enables, since the register itself reads zero
  always_comb begin
    next_irq_en = irq_en;
    if (psel && penable && pready && pwrite && pstrb[0] &&
        idx == `TT_IDX_IRQ_EN) begin
      next_irq_en = pwdata[3:1];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= 3'h0;
    end else begin
      irq_en <= next_irq_en;
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_one_wait: assert property (s_access |=> s_answer)
    else $error("access not answered by a single pulse");
  a_ready_has_cause: assert property (
    pready |-> $past(psel && penable))
    else $error("pready without an access");
  a_err_unmapped: assert property (
    s_access |=> pslverr == !$past(mapped))
    else $error("error response does not match the address");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response outside the answer cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  a_rdata_byte: assert property (prdata[31:8] == 24'h00_0000)
    else $error("read data above the low byte");
  a_wo_read_zero: assert property (
    pready && !pwrite && idx inside {`TT_IDX_IRQ_EN, `TT_IDX_T2_CTL,
    `TT_IDX_T0_CTL, `TT_IDX_T1_CTL} |-> prdata == 32'h0000_0000)
    else $error("write-only register read back non-zero");
  a_irq_masked: assert property (
    (timer_irq & ~irq_en & ~$past(irq_en)) == 3'b000)
    else $error("interrupt raised while disabled");
  a_irq_sticky: assert property (
    $fell(timer_irq[2]) |-> $past(flag_wr) || $past(flag_wr, 2))
    else $error("timer 0 interrupt dropped without software");
endmodule

bind tt_timer_unit tt_timer_unit_properties #(
  .NUM_TIMERS(NUM_TIMERS),
  .ADDR_W    (ADDR_W)
) u_tt_timer_unit_properties (
  .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port0_pin(port0_pin), .ir_pin_input(ir_pin_input),
  .timer_irq(timer_irq)
);

// ### bench/testbench.sv
// self-checking bench of the three-timer unit with capture
`timescale 1ns/1ps
`include "tt_defines.svh"
module testbench;
  import tt_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [8:0]  pins;
  logic [2:0]  timer_irq;
  int          err_count;
  int          n_compared;

  tt_timer_unit u_tt_timer_unit (
    .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pin(pins[7:0]), .ir_pin_input(pins[8]), .timer_irq(timer_irq)
  );

  // 10 MHz clock
  always begin
    #50 clk = ~clk;
  end

  // ********
  // shared tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; pready is read before the edge's updates land
  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic apb(input logic [9:0] i, input logic w, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(i, 1'b1, d, q, e);
  endtask

  task automatic rc(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(i, 1'b0, 8'h00, q, e);
    check(q, {24'h00_0000, d});
  endtask

  // pins are synchronised, so give each change time to act
  task automatic tog(input int b);
    @(posedge clk);
    pins[b] <= ~pins[b];
    repeat (5) @(posedge clk);
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (timer_irq[2] !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic measure(input logic [7:0] ctl, input logic [7:0] r,
                         output int n);
    wr(`TT_IDX_T0_CTL, 8'h00);
    wr(`TT_IDX_EVT, 8'h00);
    wr(`TT_IDX_T0_CNT, r);
    wr(`TT_IDX_T0_CTL, ctl);
    wait_irq(n);
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rc(`TT_IDX_T0_CNT, 8'h00);
    rc(`TT_IDX_T2_HI, 8'h00);
    rc(`TT_IDX_EVT, 8'h00);
    apb(10'h0e4, 1'b0, 8'h00, q, e);
    check({31'h0, e}, 32'h0000_0001);
    $display("done reset");
  endtask

  // pin clock holds the count still, so captured values are exact
  task automatic t_capture(input int t);
    logic [9:0] c;
    logic [7:0] r;
    int         k;
    c = t ? `TT_IDX_T1_CNT : `TT_IDX_T0_CNT;
    r = t ? 8'h6b : 8'h5a;
    k = 7 - t;
    wr(c, r);
    wr(c + 10'd1, 8'h93);
    tog(t);
    tog(t);
    rc(c + 10'd2, r);
    rc(c + 10'd3, ~r);
    wr(c + 10'd2, 8'h00);
    rc(c + 10'd2, r);
    tog(k);
    tog(k);
    rc(c, r - 8'h01);
    wr(c + 10'd1, 8'h00);
    wr(c + 10'd1, 8'hbb);
    tog(k);
    tog(t);
    rc(c + 10'd2, r - 8'h01);
    wr(c + 10'd1, 8'hbb);
    tog(k);
    rc(c, r - 8'h01);
    wr(c + 10'd1, 8'h00);
    tog(k);
    rc(c, r - 8'h01);
    wr(c + 10'd1, 8'h83);
    tog(8);
    tog(8);
    rc(c + 10'd2, r - 8'h01);
    wr(`TT_IDX_IR_CTL, 8'h01);
    tog(8);
    tog(8);
    rc(c + 10'd2, r);
    rc(`TT_IDX_IR_CTL, 8'h80);
    wr(`TT_IDX_IR_CTL, 8'h00);
    wr(c + 10'd1, 8'h00);
    $display("done capture");
  endtask

  task automatic t_timer2;
    wr(`TT_IDX_T2_LO, 8'h00);
    wr(`TT_IDX_T2_HI, 8'h01);
    wr(`TT_IDX_T2_CTL, 8'h83);
    rc(`TT_IDX_T2_HI, 8'h01);
    tog(5);
    tog(5);
    rc(`TT_IDX_T2_LO, 8'hff);
    rc(`TT_IDX_T2_HI, 8'h00);
    wr(`TT_IDX_T2_CTL, 8'h00);
    $display("done timer2");
  endtask

  // period difference of two reloads cancels the fixed latency
  task automatic t_period;
    int a;
    int b;
    int m;
    wr(`TT_IDX_IRQ_EN, 8'h08);
    for (int s = 0; s < 3; s++) begin
      measure(8'hc0 | 8'(s), 8'h03, a);
      measure(8'hc0 | 8'(s), 8'h0a, b);
      m = (1 << s) - 1;
      check(32'((b - a) inside {[(7 << s) - m:(7 << s) + m]}), 32'h1);
    end
    check(32'(timer_irq), 32'h0000_0004);
    rc(`TT_IDX_T0_CNT, 8'h00);
    rc(`TT_IDX_EVT, 8'h08);
    wr(`TT_IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    check(32'(timer_irq), 32'h0000_0000);
    pstrb <= 4'h0;
    wr(`TT_IDX_EVT, 8'h00);
    pstrb <= 4'h1;
    rc(`TT_IDX_EVT, 8'h08);
    wr(`TT_IDX_EVT, 8'hf7);
    rc(`TT_IDX_EVT, 8'h00);
    wr(`TT_IDX_IRQ_EN, 8'h08);
    measure(8'h80, 8'h03, a);
    wr(`TT_IDX_EVT, 8'h00);
    wait_irq(a);
    check(32'(a < 40), 32'h0000_0001);
    wr(`TT_IDX_T0_CTL, 8'h00);
    // timers 1 and 2 run out once each; timer 0 flag still stands
    wr(`TT_IDX_T1_CNT, 8'h02);
    wr(`TT_IDX_T1_CTL, 8'hc0);
    wr(`TT_IDX_T2_LO, 8'h02);
    wr(`TT_IDX_T2_HI, 8'h00);
    wr(`TT_IDX_T2_CTL, 8'hc0);
    wr(`TT_IDX_IRQ_EN, 8'h06);
    @(posedge clk);
    check(32'(timer_irq), 32'h0000_0003);
    rc(`TT_IDX_EVT, 8'h0e);
    $display("done period");
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk        = 1'b0;
    rst_b      = 1'b0;
    paddr      = 12'h000;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    pwdata     = 32'h0000_0000;
    pstrb      = 4'h1;
    pins       = 9'h1ff;
    err_count  = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_capture(0);
    t_capture(1);
    t_timer2;
    t_period;
    end_sim;
  end

  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule
